// ===== shared/lcdm_defs.svh
`ifndef LCDM_DEFS_SVH
`define LCDM_DEFS_SVH

// Register map, one byte per offset
`define LCDM_ADDR_W 5
`define LCDM_SEG_REGS 16
`define LCDM_OFF_SEG0 5'h00
`define LCDM_OFF_CTRL 5'h10
`define LCDM_OFF_PADSEL 5'h11
`define LCDM_OFF_FRAME 5'h12
`define LCDM_OFF_BIAS 5'h13

// Field positions
`define LCDM_CTRL_MUX 1:0
`define LCDM_CTRL_SLEEP 2
`define LCDM_FRM_FREQ 1:0
`define LCDM_FRM_DIV 7:5
`define LCDM_BIAS_REF 0
`define LCDM_BIAS_OFF 1
`define LCDM_BIAS_MODE 2
`define LCDM_BIAS_STDB 3
`define LCDM_BIAS_CLK 5:4

// Reset values
`define LCDM_RST_CTRL 8'h04
`define LCDM_RST_PADSEL 8'h00
`define LCDM_RST_FRAME 8'h00
`define LCDM_RST_BIAS 8'h02
`define LCDM_RST_SEG 8'h00

// Readback masks of segment data per multiplex scheme
`define LCDM_MASK_DD 8'h11
`define LCDM_MASK_2W 8'h33
`define LCDM_MASK_3W 8'h77
`define LCDM_MASK_4W 8'hFF

// Source frequencies in Hz and system clock in Hz
`define LCDM_CLK_HZ 250000000
`define LCDM_SRC_HZ_0 512
`define LCDM_SRC_HZ_1 1048
`define LCDM_SRC_HZ_2 2048
`define LCDM_SRC_HZ_3 4096

`endif

// ===== shared/lcdm_pkg.sv
package lcdm_pkg;

  typedef enum logic [1:0] {
    lcdm_mux_dd = 2'h0,
    lcdm_mux_2w = 2'h1,
    lcdm_mux_3w = 2'h2,
    lcdm_mux_4w = 2'h3
  } lcdm_mux_type;

  // Drive level index, V0 lowest to V3 highest
  typedef enum logic [1:0] {
    lcdm_v0 = 2'h0,
    lcdm_v1 = 2'h1,
    lcdm_v2 = 2'h2,
    lcdm_v3 = 2'h3
  } lcdm_level_type;

  typedef enum logic [1:0] {
    lcdm_st_idle = 2'b00,
    lcdm_st_run = 2'b01,
    lcdm_st_stop = 2'b11
  } lcdm_state_type;

endpackage : lcdm_pkg

// ===== verilog/lcdm_frame_timer.sv
`timescale 1ns/1ps
`include "lcdm_defs.svh"

module lcdm_frame_timer #(
  parameter int CLK_HZ = `LCDM_CLK_HZ,
  parameter int SRC_HZ_0 = `LCDM_SRC_HZ_0,
  parameter int SRC_HZ_1 = `LCDM_SRC_HZ_1,
  parameter int SRC_HZ_2 = `LCDM_SRC_HZ_2,
  parameter int SRC_HZ_3 = `LCDM_SRC_HZ_3
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Configuration
  input wire logic run,
  input wire logic [1:0] freq_sel,
  input wire logic [2:0] div_sel,
  input wire logic [1:0] mux_sel,
  // Frame position
  output logic [1:0] phase,
  output logic polarity,
  output logic frame_start,
  output logic frame_end
);

  localparam int PER_0 = CLK_HZ / SRC_HZ_0;
  localparam int PER_1 = CLK_HZ / SRC_HZ_1;
  localparam int PER_2 = CLK_HZ / SRC_HZ_2;
  localparam int PER_3 = CLK_HZ / SRC_HZ_3;
  localparam int CNT_W = $clog2(PER_0 + 1);

  logic [CNT_W-1:0] pre_r;
  logic [CNT_W-1:0] last_pre;
  logic [2:0] tick_r;
  logic [1:0] phase_r;
  logic pol_r;
  logic live_r;
  logic wrap_r;
  logic src_tick;
  logic slot_end;

  // Source clock selection
  always_comb begin // [R20]
    case (freq_sel)
      2'h0: last_pre = CNT_W'(PER_0 - 1);
      2'h1: last_pre = CNT_W'(PER_1 - 1);
      2'h2: last_pre = CNT_W'(PER_2 - 1);
      default: last_pre = CNT_W'(PER_3 - 1);
    endcase
  end

  assign src_tick = run && (pre_r == last_pre);
  // Divide value is code plus one, multiplex factor is code plus one
  assign slot_end = src_tick && (tick_r == div_sel); // [R20]
  assign frame_end = slot_end && (phase_r == mux_sel) && pol_r; // [R19]
  assign frame_start = run && (!live_r || wrap_r);
  assign phase = phase_r;
  assign polarity = pol_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pre_r <= '0;
    end else if (!run || src_tick) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + CNT_W'(1);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tick_r <= 3'h0;
    end else if (!run || slot_end) begin
      tick_r <= 3'h0;
    end else if (src_tick) begin
      tick_r <= tick_r + 3'h1;
    end
  end

  // Phases of one polarity, then the same phases inverted
  always_ff @(posedge clock or posedge rst) begin // [R19]
    if (rst) begin
      phase_r <= 2'h0;
      pol_r <= 1'b0;
    end else if (!run) begin
      phase_r <= 2'h0;
      pol_r <= 1'b0;
    end else if (slot_end) begin
      if (phase_r == mux_sel) begin
        phase_r <= 2'h0;
        pol_r <= !pol_r;
      end else begin
        phase_r <= phase_r + 2'h1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      live_r <= 1'b0;
      wrap_r <= 1'b0;
    end else begin
      live_r <= run;
      wrap_r <= frame_end;
    end
  end

  // Frame length check helper
  logic [31:0] len_r;
  logic cfg_ok_r;
  logic [31:0] want;
  assign want = 32'(2 * (32'(div_sel) + 1) * (32'(mux_sel) + 1)
    * (32'(last_pre) + 1));

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      len_r <= 32'h0;
      cfg_ok_r <= 1'b0;
    end else begin
      // Cycle count of the frame, its first cycle included
      len_r <= frame_start ? 32'h2 : len_r + 32'h1;
      cfg_ok_r <= frame_start ? 1'b1 : cfg_ok_r && $stable(freq_sel)
        && $stable(div_sel) && $stable(mux_sel) && run;
    end
  end

  a_frame_length: assert property ( // [R19]
    @(posedge clock) disable iff (rst)
    (frame_end && cfg_ok_r && $stable(freq_sel) && $stable(div_sel)
      && $stable(mux_sel)) |-> (len_r == want))
    else $error("frame length differs from formula");

endmodule : lcdm_frame_timer

// ===== verilog/lcdm_wave_gen.sv
`timescale 1ns/1ps
`include "lcdm_defs.svh"

module lcdm_wave_gen #(
  parameter int PINS = 32
) (
  // Latched display data
  input wire logic [PINS*4-1:0] disp_flat,
  // Frame position and mode
  input wire logic [1:0] mux_sel,
  input wire logic [1:0] phase,
  input wire logic polarity,
  input wire logic active,
  // Drive levels
  output logic [PINS*2-1:0] seg_lvl,
  output logic [1:0] com0_lvl,
  output logic [1:0] com1_lvl
);

  logic half;
  // Direct drive and 1:2 use half bias, 1:3 and 1:4 third bias
  assign half = (mux_sel == lcdm_pkg::lcdm_mux_dd)
    || (mux_sel == lcdm_pkg::lcdm_mux_2w); // [R12]

  // Every input passed in, so any change re-evaluates the pins
  function automatic logic [1:0] com_level(input logic sel, input logic act,
    input logic pol, input logic hb);
    logic [1:0] v;
    v = lcdm_pkg::lcdm_v0;
    if (!act) begin
      v = lcdm_pkg::lcdm_v0;
    end else if (sel) begin
      v = pol ? lcdm_pkg::lcdm_v0 : lcdm_pkg::lcdm_v3;
    end else if (hb) begin
      v = lcdm_pkg::lcdm_v2;
    end else begin
      v = pol ? lcdm_pkg::lcdm_v2 : lcdm_pkg::lcdm_v1;
    end
    return v;
  endfunction : com_level

  function automatic logic [1:0] seg_level(input logic on, input logic act,
    input logic pol, input logic hb);
    logic [1:0] v;
    v = lcdm_pkg::lcdm_v0;
    if (!act) begin
      v = lcdm_pkg::lcdm_v0;
    end else if (on) begin
      v = pol ? lcdm_pkg::lcdm_v3 : lcdm_pkg::lcdm_v0;
    end else if (hb) begin
      v = pol ? lcdm_pkg::lcdm_v0 : lcdm_pkg::lcdm_v3;
    end else begin
      v = pol ? lcdm_pkg::lcdm_v1 : lcdm_pkg::lcdm_v2;
    end
    return v;
  endfunction : seg_level

  assign com0_lvl = com_level(phase == 2'h0, active, polarity, half);
  assign com1_lvl = com_level(phase == 2'h1, active, polarity, half);

  // Pin p reads its nibble, bit index chosen by phase
  for (genvar p = 0; p < PINS; p++) begin : g_pin // [R21]
    logic [3:0] nib;
    assign nib = disp_flat[p*4 +: 4];
    if (p == PINS - 1) begin : g_c2
      assign seg_lvl[p*2 +: 2] = (mux_sel >= lcdm_pkg::lcdm_mux_3w)
        ? com_level(phase == 2'h2, active, polarity, half)
        : seg_level(nib[phase], active, polarity, half); // [R5]
    end else if (p == PINS - 2) begin : g_c3
      assign seg_lvl[p*2 +: 2] = (mux_sel == lcdm_pkg::lcdm_mux_4w)
        ? com_level(phase == 2'h3, active, polarity, half)
        : seg_level(nib[phase], active, polarity, half); // [R6]
    end else begin : g_seg
      assign seg_lvl[p*2 +: 2] = seg_level(nib[phase], active, polarity,
        half); // [R9]
    end
  end

endmodule : lcdm_wave_gen

// ===== verilog/lcdm_driver.sv
`timescale 1ns/1ps
`include "lcdm_defs.svh"

// Overview of operation
// R1: Code 01 gives two-way multiplexed waveforms
// R2: Code 10 gives three-way multiplexed waveforms
// R3: Code 11 gives four-way multiplexed waveforms
// R4: Two-way: 32 segment pins, two commons
// R5: Three-way: pin 31 is third common
// R6: Four-way: pins 31, 30 are commons
// R7: Two-way uses data bits 0,1,4,5 only
// R8: Three-way ignores data bits 3 and 7
// R9: Four-way uses all data bits
// R10: Software sets all pad select bits
// R11: Waveforms run while sleep bit is zero
// R12: Half bias two-way, third bias otherwise; the code also uses half bias for direct drive
// R13: Software enables reference, clears off, standby
// R14: Clock select 11 gives lowest impedance
// R15: Two-way 50 Hz: source 01, divider 100
// R16: Three-way 50 Hz: source 10, divider 110
// R17: Four-way 50 Hz: source 10, divider 100
// R18: Example two-way setup bytes for software
// R19: Frame rate is source over 2*div*mux
// R20: Source and divider codes select fixed values
// R21: Register N drives pins 2N, 2N+1
// R22: Writes apply next frame, read shows display
// R23: Display copy latched atomically at frame start

module lcdm_driver #(
  parameter int CLK_HZ = `LCDM_CLK_HZ,
  parameter int SRC_HZ_0 = `LCDM_SRC_HZ_0,
  parameter int SRC_HZ_1 = `LCDM_SRC_HZ_1,
  parameter int SRC_HZ_2 = `LCDM_SRC_HZ_2,
  parameter int SRC_HZ_3 = `LCDM_SRC_HZ_3,
  parameter int SEG_REGS = `LCDM_SEG_REGS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [`LCDM_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Panel drive levels
  output logic [SEG_REGS*4-1:0] seg_level,
  output logic [1:0] common_out_0,
  output logic [1:0] common_out_1,
  // Pad and bias generator controls
  output logic [7:0] pad_lcd_select,
  output logic internal_ref_enable,
  output logic bias_gen_off,
  output logic bias_gen_standby,
  output logic bias_mode,
  output logic [1:0] bias_clock_select,
  output logic frame_active
);

  localparam int PINS = SEG_REGS * 2;

  logic [7:0] shadow_r [SEG_REGS];
  logic [7:0] disp_r [SEG_REGS];
  logic [7:0] ctrl_r;
  logic [7:0] padsel_r;
  logic [7:0] frame_r;
  logic [7:0] bias_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] seg_mask;
  lcdm_pkg::lcdm_state_type state_r;
  lcdm_pkg::lcdm_state_type state_nxt;
  logic [PINS*4-1:0] disp_flat;
  logic [PINS*2-1:0] seg_lvl_w;
  logic [PINS*2-1:0] seg_level_r;
  logic [1:0] com0_w;
  logic [1:0] com1_w;
  logic [1:0] com0_r;
  logic [1:0] com1_r;
  logic active_r;
  logic [1:0] mux_sel;
  logic sleep;
  logic run;
  logic [1:0] phase;
  logic polarity;
  logic frame_load;
  logic frame_end;
  logic seg_hit;

  assign mux_sel = ctrl_r[`LCDM_CTRL_MUX];
  assign sleep = ctrl_r[`LCDM_CTRL_SLEEP];
  assign run = (state_r != lcdm_pkg::lcdm_st_idle);
  assign seg_hit = (reg_addr < `LCDM_ADDR_W'(SEG_REGS));
  // Load ahead of a frame's first cycle, so no cycle shows stale data
  assign frame_load = frame_end
    || (state_r == lcdm_pkg::lcdm_st_idle && !sleep); // [R23]

  // Configuration registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_r <= `LCDM_RST_CTRL;
      padsel_r <= `LCDM_RST_PADSEL;
      frame_r <= `LCDM_RST_FRAME;
      bias_r <= `LCDM_RST_BIAS;
    end else if (reg_wr) begin
      case (reg_addr)
        `LCDM_OFF_CTRL: ctrl_r <= reg_wdata; // [R1] [R2] [R3] [R11]
        `LCDM_OFF_PADSEL: padsel_r <= reg_wdata;
        `LCDM_OFF_FRAME: frame_r <= reg_wdata;
        `LCDM_OFF_BIAS: bias_r <= reg_wdata; // [R12] [R14]
        default: ;
      endcase
    end
  end

  // Software copy, accepted at any time, even asleep
  for (genvar n = 0; n < SEG_REGS; n++) begin : g_reg
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        shadow_r[n] <= `LCDM_RST_SEG;
      end else if (reg_wr && reg_addr == `LCDM_ADDR_W'(n)) begin
        shadow_r[n] <= reg_wdata; // [R22]
      end
    end

    // Shown copy changes only at a frame boundary
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        disp_r[n] <= `LCDM_RST_SEG;
      end else if (frame_load) begin
        disp_r[n] <= shadow_r[n]; // [R22] [R23]
      end
    end

    assign disp_flat[n*8 +: 8] = disp_r[n]; // [R21]
  end

  // Sleep takes effect at the end of a frame
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      lcdm_pkg::lcdm_st_idle:
        if (!sleep) state_nxt = lcdm_pkg::lcdm_st_run; // [R11]
      lcdm_pkg::lcdm_st_run:
        if (sleep) state_nxt = lcdm_pkg::lcdm_st_stop;
      lcdm_pkg::lcdm_st_stop:
        if (!sleep) begin
          state_nxt = lcdm_pkg::lcdm_st_run;
        end else if (frame_end) begin
          state_nxt = lcdm_pkg::lcdm_st_idle; // [R11]
        end
      default: state_nxt = lcdm_pkg::lcdm_st_idle;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= lcdm_pkg::lcdm_st_idle;
    end else begin
      state_r <= state_nxt;
    end
  end

  lcdm_frame_timer #(
    .CLK_HZ(CLK_HZ),
    .SRC_HZ_0(SRC_HZ_0),
    .SRC_HZ_1(SRC_HZ_1),
    .SRC_HZ_2(SRC_HZ_2),
    .SRC_HZ_3(SRC_HZ_3)
  ) u_timer (
    .clock(clock),
    .rst(rst),
    .run(run),
    .freq_sel(frame_r[`LCDM_FRM_FREQ]),
    .div_sel(frame_r[`LCDM_FRM_DIV]),
    .mux_sel(mux_sel),
    .phase(phase),
    .polarity(polarity),
    .frame_start(),
    .frame_end(frame_end)
  );

  lcdm_wave_gen #(
    .PINS(PINS)
  ) u_wave (
    .disp_flat(disp_flat),
    .mux_sel(mux_sel),
    .phase(phase),
    .polarity(polarity),
    .active(run),
    .seg_lvl(seg_lvl_w),
    .com0_lvl(com0_w),
    .com1_lvl(com1_w)
  );

  // Registered pin levels
  always_ff @(posedge clock or posedge rst) begin // [R4]
    if (rst) begin
      seg_level_r <= '0;
      com0_r <= lcdm_pkg::lcdm_v0;
      com1_r <= lcdm_pkg::lcdm_v0;
      active_r <= 1'b0;
    end else begin
      seg_level_r <= seg_lvl_w;
      com0_r <= com0_w;
      com1_r <= com1_w;
      active_r <= run;
    end
  end

  // Unused data bits read back as zero
  always_comb begin
    case (mux_sel)
      lcdm_pkg::lcdm_mux_dd: seg_mask = `LCDM_MASK_DD;
      lcdm_pkg::lcdm_mux_2w: seg_mask = `LCDM_MASK_2W; // [R7]
      lcdm_pkg::lcdm_mux_3w: seg_mask = `LCDM_MASK_3W; // [R8]
      default: seg_mask = `LCDM_MASK_4W; // [R9]
    endcase
  end

  always_comb begin
    rdata_nxt = 8'h00;
    if (seg_hit) begin
      rdata_nxt = disp_r[reg_addr[3:0]] & seg_mask; // [R22]
    end else begin
      case (reg_addr)
        `LCDM_OFF_CTRL: rdata_nxt = ctrl_r;
        `LCDM_OFF_PADSEL: rdata_nxt = padsel_r;
        `LCDM_OFF_FRAME: rdata_nxt = frame_r;
        `LCDM_OFF_BIAS: rdata_nxt = bias_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign reg_rdata = rdata_r;
  assign seg_level = seg_level_r;
  assign common_out_0 = com0_r;
  assign common_out_1 = com1_r;
  assign frame_active = active_r;
  assign pad_lcd_select = padsel_r;
  assign internal_ref_enable = bias_r[`LCDM_BIAS_REF];
  assign bias_gen_off = bias_r[`LCDM_BIAS_OFF];
  assign bias_gen_standby = bias_r[`LCDM_BIAS_STDB];
  assign bias_mode = bias_r[`LCDM_BIAS_MODE]; // [R12]
  assign bias_clock_select = bias_r[`LCDM_BIAS_CLK]; // [R14]

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_stopping;
    state_r == lcdm_pkg::lcdm_st_stop && sleep;
  endsequence

  sequence s_last_slot;
    s_stopping ##0 frame_end;
  endsequence

  a_stop_frame_end: assert property ( // [R11]
    s_last_slot |=> state_r == lcdm_pkg::lcdm_st_idle ##1
      (com0_r == lcdm_pkg::lcdm_v0 && !frame_active))
    else $error("sleep did not stop at frame end");

  a_stop_holds: assert property ( // [R11]
    (s_stopping ##0 !frame_end) |=> state_r != lcdm_pkg::lcdm_st_idle)
    else $error("waveform stopped before frame end");

  a_write_deferred: assert property ( // [R22]
    (reg_wr && reg_addr == `LCDM_OFF_SEG0 && !frame_load)
      |=> disp_r[0] == $past(disp_r[0]))
    else $error("segment write took effect mid frame");

  a_frame_latch: assert property ( // [R23]
    frame_load |=> disp_r[SEG_REGS-1] == $past(shadow_r[SEG_REGS-1])
      && disp_r[0] == $past(shadow_r[0]))
    else $error("display copy not latched at frame start");

  a_read_mask_2w: assert property ( // [R7]
    (reg_rd && seg_hit && mux_sel == lcdm_pkg::lcdm_mux_2w)
      |=> (reg_rdata & 8'hCC) == 8'h00)
    else $error("unused two-way bits read nonzero");

  a_read_mask_3w: assert property ( // [R8]
    (reg_rd && seg_hit && mux_sel == lcdm_pkg::lcdm_mux_3w)
      |=> (reg_rdata & 8'h88) == 8'h00)
    else $error("bits 3 and 7 read nonzero in three-way");

  a_read_full_4w: assert property ( // [R9]
    (reg_rd && reg_addr == `LCDM_OFF_SEG0
      && mux_sel == lcdm_pkg::lcdm_mux_4w) |=> reg_rdata == $past(disp_r[0]))
    else $error("four-way readback differs from display");

  a_pin31_common: assert property ( // [R5]
    (run && mux_sel == lcdm_pkg::lcdm_mux_3w && phase == 2'h2)
      |=> seg_level_r[PINS*2-1 -: 2] ==
      ($past(polarity) ? lcdm_pkg::lcdm_v0 : lcdm_pkg::lcdm_v3))
    else $error("pin 31 not driven as third common");

  a_pin30_common: assert property ( // [R6]
    (run && mux_sel == lcdm_pkg::lcdm_mux_4w && phase == 2'h3
      && $stable(polarity)) |=> seg_level_r[PINS*2-3 -: 2] ==
      ($past(polarity) ? lcdm_pkg::lcdm_v0 : lcdm_pkg::lcdm_v3))
    else $error("pin 30 not driven as fourth common");

  a_com_select_2w: assert property ( // [R1] [R4]
    (run && mux_sel == lcdm_pkg::lcdm_mux_2w && phase == 2'h1
      && !polarity) |=> com1_r == lcdm_pkg::lcdm_v3
      && com0_r == lcdm_pkg::lcdm_v2)
    else $error("two-way common levels wrong");

  a_phase_range: assert property ( // [R2] [R3]
    run |-> phase <= mux_sel)
    else $error("phase beyond multiplex factor");

endmodule : lcdm_driver

// ===== dv/lcdm_panel.sv
`timescale 1ns/1ps

module lcdm_panel (
  // Clock and wiring
  input wire logic clock,
  input wire logic [1:0] mux,
  // Drive levels seen on the glass
  input wire logic [63:0] seg_level,
  input wire logic [1:0] common_out_0,
  input wire logic [1:0] common_out_1,
  // Observed phase and lit segments
  output logic obs_valid,
  output logic [1:0] obs_phase,
  output logic obs_pol,
  output logic [31:0] obs_lit
);
  logic [1:0] com [4];
  logic [1:0] sel;
  logic pol;
  logic hit;
  logic [31:0] lit;

  always_comb begin
    int n;
    n = 0;
    com[0] = common_out_0;
    com[1] = common_out_1;
    com[2] = seg_level[63:62];
    com[3] = seg_level[61:60];
    sel = 2'h0;
    pol = 1'b0;
    for (int k = 0; k <= int'(mux); k++) begin
      if (com[k] == 2'h3 || com[k] == 2'h0) begin
        n++;
        sel = 2'(k);
        pol = (com[k] == 2'h0);
      end
    end
    hit = (n == 1) && (mux != 2'h0);
    for (int p = 0; p < 32; p++) begin
      lit[p] = hit && (seg_level[2*p+:2] == ~com[sel]);
    end
    lit[31] = lit[31] && (mux < 2'h2);
    lit[30] = lit[30] && (mux != 2'h3);
  end

  // One report per new selected common
  always_ff @(posedge clock) begin
    obs_valid <= hit && (sel !== obs_phase || pol !== obs_pol);
    if (hit) begin
      obs_phase <= sel;
      obs_pol <= pol;
      obs_lit <= lit;
    end
  end
endmodule : lcdm_panel

// ===== dv/lcdm_driver_test.sv
`timescale 1ns/1ps
`include "lcdm_defs.svh"

module lcdm_driver_test;
  typedef struct {logic [1:0] ph; logic [31:0] lit;} lcdm_note_type;
  logic clock, rst, reg_wr, reg_rd, rd_d1;
  logic [`LCDM_ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, pad_lcd_select;
  logic [63:0] seg_level;
  logic [1:0] common_out_0, common_out_1, bias_clock_select, mux;
  logic internal_ref_enable, bias_gen_off, bias_gen_standby, bias_mode;
  logic frame_active, obs_valid, obs_pol;
  logic [1:0] obs_phase;
  logic [31:0] obs_lit;
  logic [7:0] disp [16];
  logic [7:0] rd_q [$];
  lcdm_note_type lit_q [$];
  lcdm_note_type nt;
  int n_errors = 0;
  int comparisons = 0;
  int tm [5] = '{1, 2, 3, 3, 1};
  int tf [5] = '{1, 2, 2, 0, 3};
  int td [5] = '{4, 6, 4, 0, 7};

  lcdm_driver #(.SRC_HZ_0(6250000), .SRC_HZ_1(12500000),
    .SRC_HZ_2(25000000), .SRC_HZ_3(50000000)) lcdm_driver_i (
    .clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .seg_level(seg_level),
    .common_out_0(common_out_0), .common_out_1(common_out_1),
    .pad_lcd_select(pad_lcd_select),
    .internal_ref_enable(internal_ref_enable),
    .bias_gen_off(bias_gen_off), .bias_gen_standby(bias_gen_standby),
    .bias_mode(bias_mode), .bias_clock_select(bias_clock_select),
    .frame_active(frame_active));

  lcdm_panel lcdm_panel_i (.clock(clock), .mux(mux),
    .seg_level(seg_level), .common_out_0(common_out_0),
    .common_out_1(common_out_1), .obs_valid(obs_valid),
    .obs_phase(obs_phase), .obs_pol(obs_pol), .obs_lit(obs_lit));

  task automatic check(input string what, input logic [63:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      n_errors++;
    end
  endtask : check

  task automatic conclude();
    $display("Counts: %0d compared, %0d mismatched", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
  endtask : rd

  // Cycles between two starts of phase 0, first polarity
  task automatic frame_len(output int n);
    int c;
    n = 0;
    for (int s = 0; s < 2; s++) begin
      c = 0;
      do begin
        @(negedge clock);
        c++;
      end while (!(obs_valid === 1'b1 && obs_phase === 2'h0 &&
                   obs_pol === 1'b0) && c < 3000);
      if (c >= 3000) begin
        n_errors++;
        conclude();
      end
      n = c;
    end
  endtask : frame_len

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Result watcher
  always @(posedge clock) begin
    rd_d1 <= reg_rd;
    if (rd_d1 === 1'b1) begin
      check("read data", reg_rdata, rd_q.pop_front());
    end
    if (obs_valid === 1'b1 && lit_q.size() > 0) begin
      if (obs_phase === lit_q[0].ph) begin
        nt = lit_q.pop_front();
        check("lit", obs_lit, nt.lit);
      end
    end
  end

  initial begin
    int m, f, d, fl, c;
    logic [7:0] v, mk;
    logic [31:0] lv;
    lcdm_note_type n;
    rst = 1'b1;
    reg_addr = '0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    mux = 2'h0;
    void'($urandom(32'h6e9f));
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    check("idle active", frame_active, 1'b0);
    check("idle levels", seg_level, 64'h0);
    rd(`LCDM_OFF_CTRL, `LCDM_RST_CTRL);
    rd(`LCDM_OFF_PADSEL, `LCDM_RST_PADSEL);
    rd(`LCDM_OFF_FRAME, `LCDM_RST_FRAME);
    rd(`LCDM_OFF_BIAS, `LCDM_RST_BIAS);
    for (int i = 0; i < 16; i++) begin
      rd(5'(i), `LCDM_RST_SEG);
    end
    wr(5'h1f, 8'haa);
    rd(5'h1f, 8'h00);
    $display("Test reset values and map done");
    wr(`LCDM_OFF_PADSEL, 8'hff);
    for (int e = 0; e < 5; e++) begin
      m = tm[e];
      f = tf[e];
      d = td[e];
      wr(`LCDM_OFF_BIAS, (m == 1) ? 8'h35 : 8'h31);
      wr(`LCDM_OFF_FRAME, {d[2:0], 3'h0, f[1:0]});
      wr(`LCDM_OFF_CTRL, {5'h0, 1'b1, m[1:0]});
      mux <= m[1:0];
      for (int i = 0; i < 16; i++) begin
        disp[i] = 8'($urandom());
        wr(5'(i), disp[i]);
      end
      check("pad select", pad_lcd_select, 8'hff);
      check("bias", {internal_ref_enable, bias_gen_off, bias_gen_standby,
        bias_mode, bias_clock_select}, {3'b100, m == 1, 2'h3});
      wr(`LCDM_OFF_CTRL, {5'h0, 1'b0, m[1:0]});
      frame_len(fl);
      check("frame", fl, 2 * (d + 1) * (m + 1) * (40 >> f));
      mk = (m == 1) ? 8'h33 : (m == 2) ? 8'h77 : 8'hff;
      v = 8'($urandom());
      wr(5'h00, v);
      rd(5'h00, disp[0] & mk);
      disp[0] = v;
      frame_len(fl);
      rd(5'h00, v & mk);
      for (int r = 0; r < 2 * (m + 1); r++) begin
        for (int p = 0; p < 32; p++) begin
          lv[p] = disp[p / 2][4 * (p % 2) + r % (m + 1)];
        end
        lv[31] = lv[31] && (m < 2);
        lv[30] = lv[30] && (m != 3);
        n.ph = 2'(r % (m + 1));
        n.lit = lv;
        lit_q.push_back(n);
      end
      for (c = 0; lit_q.size() > 0 && c < 3000; c++) begin
        @(negedge clock);
      end
      wr(`LCDM_OFF_CTRL, {5'h0, 1'b1, m[1:0]});
      for (c = c; frame_active !== 1'b0 && c < 6000; c++) begin
        @(negedge clock);
      end
      if (c >= 3000 && lit_q.size() > 0 || c >= 6000) begin
        n_errors++;
        conclude();
      end
      check("sleep levels", seg_level, 64'h0);
      check("sleep commons", {common_out_0, common_out_1}, 4'h0);
      $display("Test scheme %0d case %0d done", m, e);
    end
    conclude();
  end
endmodule : lcdm_driver_test
